// ===== pcuirq_pkg.sv
package pcuirq_pkg;

    // Register byte offsets
    localparam logic [11:0] CAPTURE_COUNTER_CONFIG_OFS = 12'h0e8;
    localparam logic [11:0] CAPTURE_COUNTER_PHASE_OFS = 12'h0ec;
    localparam logic [11:0] CAPTURE_CHANNEL0_CONFIG_OFS = 12'h0f0;
    localparam logic [11:0] CAPTURE_CHANNEL1_CONFIG_OFS = 12'h0f4;
    localparam logic [11:0] CAPTURE_CHANNEL2_CONFIG_OFS = 12'h0f8;
    localparam logic [11:0] CAPTURE_CHANNEL0_VALUE_OFS = 12'h0fc;
    localparam logic [11:0] CAPTURE_CHANNEL1_VALUE_OFS = 12'h100;
    localparam logic [11:0] CAPTURE_CHANNEL2_VALUE_OFS = 12'h104;
    localparam logic [11:0] CAPTURE_EDGE_STATUS_OFS = 12'h108;
    localparam logic [11:0] ACTIVE_UPDATE_CONTROL_OFS = 12'h10c;
    localparam logic [11:0] INTERRUPT_ENABLE_OFS = 12'h110;
    localparam logic [11:0] INTERRUPT_RAW_OFS = 12'h114;
    localparam logic [11:0] INTERRUPT_MASKED_OFS = 12'h118;

    // Sizes
    localparam int NUM_CHAN = 3;
    localparam int NUM_OPER = 3;
    localparam int NUM_SRC = 30;
    localparam int NUM_EXT_SRC = 27;
    localparam int DIV_W = 8;
    localparam int SYNC_SRC_W = 6;

    // Capture channel config fields
    localparam int CH_ENABLE_BIT = 0;
    localparam int CH_EDGE_LO = 1;
    localparam int CH_DIV_LO = 3;
    localparam int CH_INVERT_BIT = 11;
    localparam int CH_SOFT_BIT = 12;
    localparam int EDGE_FALL_BIT = 0;
    localparam int EDGE_RISE_BIT = 1;
    localparam logic EDGE_CODE_RISE = 1'b0;
    localparam logic EDGE_CODE_FALL = 1'b1;

    // Capture counter config fields
    localparam int CNT_ENABLE_BIT = 0;
    localparam int CNT_SYNC_EN_BIT = 1;
    localparam int CNT_SYNC_SEL_LO = 2;
    localparam int CNT_SOFT_SYNC_BIT = 5;
    localparam int CNT_CFG_W = 5;

    // Update control fields
    localparam int UPD_GLOBAL_EN_BIT = 0;
    localparam int UPD_GLOBAL_FORCE_BIT = 1;
    localparam int UPD_OPER_LO = 2;
    localparam int UPD_W = 8;

    // Interrupt layout: capture sources sit above the external ones
    localparam int INT_CAP_LO = 27;

    // Reset value and count step
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-channel configuration
    typedef struct packed {
        logic invert;
        logic [DIV_W-1:0] divider;
        logic [1:0] edge_select;
        logic enable;
    } pcuirq_chan_cfg_type;

    // One capture result
    typedef struct packed {
        logic [31:0] value;
        logic last_edge;
    } pcuirq_capture_type;

endpackage : pcuirq_pkg

// ===== pcuirq_toggle_det.sv
`timescale 1ns/1ps
module pcuirq_toggle_det #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched bits and change pulses
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] change_pulse
);
    // Previous value of each watched bit
    logic [WIDTH-1:0] prev_r;

    // Remember last value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= level_in;
        end
    end

    // Any difference is a one-cycle pulse
    assign change_pulse = level_in ^ prev_r;
endmodule : pcuirq_toggle_det

// ===== pcuirq_cap_chan.sv
`timescale 1ns/1ps
module pcuirq_cap_chan
    import pcuirq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration and triggers
    input wire pcuirq_pkg::pcuirq_chan_cfg_type cfg,
    input wire logic soft_trigger,
    input wire logic cap_in,
    input wire logic [31:0] counter_value,
    // Results
    output logic capture_pulse,
    output pcuirq_pkg::pcuirq_capture_type result_r
);
    logic sig; // Input after optional inversion
    logic sig_prev_r; // Last inverted sample
    logic [DIV_W-1:0] div_cnt_r; // Rising edges counted so far
    logic div_sig_r; // Prescaled signal
    logic div_prev_r; // Last prescaled sample
    logic in_rise;
    logic in_fall;
    logic div_hit;
    logic div_rise;
    logic div_fall;
    logic edge_cap;

    assign sig = cap_in ^ cfg.invert;
    assign in_rise = sig & ~sig_prev_r;
    assign in_fall = ~sig & sig_prev_r;
    assign div_hit = in_rise && (div_cnt_r == cfg.divider);

    // Input sampling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_prev_r <= 1'b0;
        end else begin
            sig_prev_r <= sig;
        end
    end

    // Count rising edges; pass one in divider+1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
        end else if (div_hit) begin
            div_cnt_r <= '0;
        end else if (in_rise) begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    // Prescaled level rises on the passed edge, falls with the input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_sig_r <= 1'b0;
            div_prev_r <= 1'b0;
        end else begin
            div_prev_r <= div_sig_r;
            if (div_hit) begin
                div_sig_r <= 1'b1;
            end else if (in_fall) begin
                div_sig_r <= 1'b0;
            end
        end
    end

    assign div_rise = div_sig_r & ~div_prev_r;
    assign div_fall = ~div_sig_r & div_prev_r;
    // Edge selection after prescaling, only while enabled
    assign edge_cap = cfg.enable &&
        ((div_rise && cfg.edge_select[EDGE_RISE_BIT]) ||
         (div_fall && cfg.edge_select[EDGE_FALL_BIT]));
    assign capture_pulse = edge_cap || soft_trigger;

    // Latch counter and edge kind
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= '0;
        end else if (capture_pulse) begin
            result_r.value <= counter_value;
            if (edge_cap) begin
                result_r.last_edge <= div_fall ? EDGE_CODE_FALL : EDGE_CODE_RISE;
            end
        end
    end
endmodule : pcuirq_cap_chan

// ===== pcuirq_top.sv
// Summary of operation
// - Edge field: bit0 falling, bit1 rising
// - Channel edge captures only while enabled; software capture ignores enable
// - Software bit forces immediate channel capture
// - Invert bit flips input before prescaler
// - Prescaler divides rising edges by field+1
// - Value register holds last captured counter
// - Edge bit: 0 rising, 1 falling
// - Operator force bit toggle forces update
// - Operator update needs own and global enable
// - Global force toggle updates whole unit
// - Global enable gates global and operator update allows; force updates ignore it
// - Capture interrupt enable per channel
// - One-shot and cycle fault action enables
// - Operator event A and B enables
// - Fault start and fault end enables
// - Timer zero and period event enables
// - Timer stop event enables
// - Capture counter increments while enabled
// - Sync loads counter from phase register
// - Raw status set regardless of enable
// - Masked status is raw and enable
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module pcuirq_top
    import pcuirq_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // AXI4-Lite write address
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Capture inputs and sync sources
    input wire logic [2:0] CAPTURE_IN,
    input wire logic [5:0] SYNC_IN,
    // Event pulses from timers, operators and fault logic
    input wire logic [26:0] EVENT_IN,
    // Active register update control toward the operators
    output logic [2:0] OPERATOR_FORCE_UPDATE,
    output logic [2:0] OPERATOR_UPDATE_ALLOW,
    output logic GLOBAL_FORCE_UPDATE,
    output logic GLOBAL_UPDATE_ALLOW
);
    import pcuirq_pkg::*;

    // Bus handshake state
    logic aw_hold_r; // Write address taken
    logic w_hold_r; // Write data taken
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_write; // Both halves present
    logic do_read; // Read address handshake

    // Software registers
    logic [CNT_CFG_W-1:0] counter_cfg_r; // Enable, sync enable, sync select
    logic [31:0] phase_r; // Capture counter phase
    pcuirq_chan_cfg_type chan_cfg_r [NUM_CHAN]; // Channel configs
    logic [UPD_W-1:0] update_r; // Active update control
    logic [NUM_SRC-1:0] int_ena_r; // Interrupt enables
    logic [NUM_SRC-1:0] int_raw_r; // Sticky raw status

    // Hardware state
    logic [31:0] counter_r; // Capture counter
    logic sync_prev_r; // Selected sync level, last cycle
    logic [NUM_CHAN-1:0] soft_cap_r; // Write-only capture pulses
    logic soft_sync_r; // Write-only sync pulse
    pcuirq_capture_type cap_res [NUM_CHAN];
    logic [NUM_CHAN-1:0] cap_pulse;
    logic [UPD_W-1:0] upd_change;
    logic [NUM_SRC-1:0] src_pulse;
    logic [NUM_SRC-1:0] raw_clear;
    logic sync_level;
    logic sync_event;
    logic [2:0] sync_sel;

    // Apply byte strobes to a word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Write channel acceptance
    assign S_AXI_AWREADY = !aw_hold_r;
    assign S_AXI_WREADY = !w_hold_r;
    assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;

    // Hold address and data until both are here
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (S_AXI_AWVALID && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (S_AXI_WVALID && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only words answer with an error
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            unique case (awaddr_r)
                CAPTURE_COUNTER_CONFIG_OFS, CAPTURE_COUNTER_PHASE_OFS,
                CAPTURE_CHANNEL0_CONFIG_OFS, CAPTURE_CHANNEL1_CONFIG_OFS,
                CAPTURE_CHANNEL2_CONFIG_OFS, ACTIVE_UPDATE_CONTROL_OFS,
                INTERRUPT_ENABLE_OFS, INTERRUPT_RAW_OFS: bresp_r <= RESP_OKAY;
                default: bresp_r <= RESP_SLVERR;
            endcase
        end else if (S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // Capture counter configuration and phase
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            counter_cfg_r <= '0;
            phase_r <= ZERO_WORD;
        end else if (do_write) begin
            if (awaddr_r == CAPTURE_COUNTER_CONFIG_OFS) begin
                counter_cfg_r <= CNT_CFG_W'(merge_bytes({27'h0, counter_cfg_r}, wdata_r,
                                             wstrb_r));
            end
            if (awaddr_r == CAPTURE_COUNTER_PHASE_OFS) begin
                phase_r <= merge_bytes(phase_r, wdata_r, wstrb_r);
            end
        end
    end

    // Write-only pulses: soft sync and soft captures
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            soft_sync_r <= 1'b0;
            soft_cap_r <= '0;
        end else begin
            soft_sync_r <= do_write && (awaddr_r == CAPTURE_COUNTER_CONFIG_OFS)
                && wstrb_r[0] && wdata_r[CNT_SOFT_SYNC_BIT];
            for (int c = 0; c < NUM_CHAN; c++) begin
                soft_cap_r[c] <= do_write && wstrb_r[1] && wdata_r[CH_SOFT_BIT] &&
                    (awaddr_r == CAPTURE_CHANNEL0_CONFIG_OFS + 12'(4 * c));
            end
        end
    end

    // Channel configuration registers
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                chan_cfg_r[c] <= '0;
            end
        end else if (do_write) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (awaddr_r == CAPTURE_CHANNEL0_CONFIG_OFS + 12'(4 * c)) begin
                    chan_cfg_r[c] <= CH_SOFT_BIT'(merge_bytes({20'h0, chan_cfg_r[c]}, wdata_r,
                                                 wstrb_r));
                end
            end
        end
    end

    // Update control and interrupt enable registers
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            update_r <= '0;
            int_ena_r <= '0;
        end else if (do_write) begin
            if (awaddr_r == ACTIVE_UPDATE_CONTROL_OFS) begin
                update_r <= UPD_W'(merge_bytes({24'h0, update_r}, wdata_r, wstrb_r));
            end
            if (awaddr_r == INTERRUPT_ENABLE_OFS) begin
                int_ena_r <= NUM_SRC'(merge_bytes({2'h0, int_ena_r}, wdata_r,
                                         wstrb_r));
            end
        end
    end

    // Selected sync source; code 0 means none
    assign sync_sel = counter_cfg_r[CNT_SYNC_SEL_LO +: 3];
    assign sync_level = (sync_sel != 3'h0) && (sync_sel <= 3'(SYNC_SRC_W)) &&
        SYNC_IN[3'(sync_sel - 3'h1)];
    assign sync_event = (counter_cfg_r[CNT_SYNC_EN_BIT] && sync_level && !sync_prev_r)
        || soft_sync_r;

    // Sync source edge detection
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync_prev_r <= 1'b0;
        end else begin
            sync_prev_r <= sync_level;
        end
    end

    // Capture counter: sync load wins over counting
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            counter_r <= ZERO_WORD;
        end else if (sync_event) begin
            counter_r <= phase_r;
        end else if (counter_cfg_r[CNT_ENABLE_BIT]) begin
            counter_r <= counter_r + COUNT_STEP;
        end
    end

    // One capture channel per input
    generate
        for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
            pcuirq_cap_chan u_chan (
                .clk(CORE_CLK),
                .rst_n(RESETN),
                .cfg(chan_cfg_r[g]),
                .soft_trigger(soft_cap_r[g]),
                .cap_in(CAPTURE_IN[g]),
                .counter_value(counter_r),
                .capture_pulse(cap_pulse[g]),
                .result_r(cap_res[g])
            );
        end
    endgenerate

    // Force update toggles on every force bit
    pcuirq_toggle_det #(.WIDTH(UPD_W)) u_toggle (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .level_in(update_r),
        .change_pulse(upd_change)
    );

    // Update outputs toward the operators
    assign GLOBAL_UPDATE_ALLOW = update_r[UPD_GLOBAL_EN_BIT];
    assign GLOBAL_FORCE_UPDATE = upd_change[UPD_GLOBAL_FORCE_BIT];
    generate
        for (genvar o = 0; o < NUM_OPER; o++) begin : g_oper
            assign OPERATOR_UPDATE_ALLOW[o] = update_r[UPD_OPER_LO + 2 * o] &&
                update_r[UPD_GLOBAL_EN_BIT];
            assign OPERATOR_FORCE_UPDATE[o] = upd_change[UPD_OPER_LO + 2 * o + 1] ||
                upd_change[UPD_GLOBAL_FORCE_BIT];
        end
    endgenerate

    // Interrupt sources; captures occupy the top bits
    assign src_pulse = {cap_pulse, EVENT_IN};
    assign raw_clear = (do_write && awaddr_r == INTERRUPT_RAW_OFS) ?
        NUM_SRC'(merge_bytes(ZERO_WORD, wdata_r, wstrb_r)) : '0;

    // Sticky raw status: a new event beats a clear
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            int_raw_r <= '0;
        end else begin
            int_raw_r <= (int_raw_r & ~raw_clear) | src_pulse;
        end
    end

    // Read channel
    assign do_read = S_AXI_ARVALID && !rvalid_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    // Read data mux, registered
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid_r <= 1'b0;
            rdata_r <= ZERO_WORD;
            rresp_r <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            unique case (S_AXI_ARADDR)
                CAPTURE_COUNTER_CONFIG_OFS: rdata_r <= {27'h0, counter_cfg_r};
                CAPTURE_COUNTER_PHASE_OFS: rdata_r <= phase_r;
                CAPTURE_CHANNEL0_CONFIG_OFS: rdata_r <= {20'h0, chan_cfg_r[0]};
                CAPTURE_CHANNEL1_CONFIG_OFS: rdata_r <= {20'h0, chan_cfg_r[1]};
                CAPTURE_CHANNEL2_CONFIG_OFS: rdata_r <= {20'h0, chan_cfg_r[2]};
                CAPTURE_CHANNEL0_VALUE_OFS: rdata_r <= cap_res[0].value;
                CAPTURE_CHANNEL1_VALUE_OFS: rdata_r <= cap_res[1].value;
                CAPTURE_CHANNEL2_VALUE_OFS: rdata_r <= cap_res[2].value;
                CAPTURE_EDGE_STATUS_OFS: rdata_r <= {29'h0, cap_res[2].last_edge,
                    cap_res[1].last_edge, cap_res[0].last_edge};
                ACTIVE_UPDATE_CONTROL_OFS: rdata_r <= {24'h0, update_r};
                INTERRUPT_ENABLE_OFS: rdata_r <= {2'h0, int_ena_r};
                INTERRUPT_RAW_OFS: rdata_r <= {2'h0, int_raw_r};
                INTERRUPT_MASKED_OFS: rdata_r <= {2'h0, int_raw_r & int_ena_r};
                default: begin
                    rdata_r <= ZERO_WORD;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : pcuirq_top

// ===== pcuirq_asserts.sv
`timescale 1ns/1ps
module pcuirq_asserts (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Bus handshakes
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    // Update control
    input wire logic [2:0] OPERATOR_FORCE_UPDATE,
    input wire logic [2:0] OPERATOR_UPDATE_ALLOW,
    input wire logic GLOBAL_FORCE_UPDATE,
    input wire logic GLOBAL_UPDATE_ALLOW
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    // Operator allow needs the global allow
    op_allow_a: assert property (!GLOBAL_UPDATE_ALLOW |-> OPERATOR_UPDATE_ALLOW == 3'h0)
        else $error("operator allow without global allow");
    // Global force reaches every operator
    global_force_a: assert property (GLOBAL_FORCE_UPDATE |-> OPERATOR_FORCE_UPDATE == 3'h7)
        else $error("global force missed an operator");
    // Force pulses last one cycle
    gforce_pulse_a: assert property (GLOBAL_FORCE_UPDATE |=> !GLOBAL_FORCE_UPDATE)
        else $error("global force pulse too long");
    opforce_pulse_a: assert property (|OPERATOR_FORCE_UPDATE |=> !(|OPERATOR_FORCE_UPDATE))
        else $error("operator force pulse too long");
    // Force and allow only move with a finished write
    force_write_a: assert property (|OPERATOR_FORCE_UPDATE |-> $rose(S_AXI_BVALID))
        else $error("force pulse without a write");
    allow_write_a: assert property (
        !$stable({GLOBAL_UPDATE_ALLOW, OPERATOR_UPDATE_ALLOW}) |-> $rose(S_AXI_BVALID))
        else $error("allow changed without a write");
    // Read answer one cycle after the address
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken during answer");
endmodule : pcuirq_asserts
bind pcuirq_top pcuirq_asserts u_chk (.*);

// ===== pcuirq_cap_src.sv
`timescale 1ns/1ps
module pcuirq_cap_src (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Toggle requests and capture lines
    input wire logic [2:0] flip,
    output logic [2:0] cap
);
    // Each requested line changes level at the next edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap <= 3'h0;
        end else begin
            cap <= cap ^ flip;
        end
    end
endmodule : pcuirq_cap_src

// ===== pcuirq_tb_top.sv
`timescale 1ns/1ps
module pcuirq_tb_top;
    import pcuirq_pkg::*;
    // Drives
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
    logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
    logic [31:0] w_data = 32'h0;
    logic [2:0] flip = 3'h0;
    logic [26:0] ev = 27'h0;
    // Design outputs
    logic awready, wready, bvalid, arready, rvalid, g_force, g_allow;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rdv;
    logic [2:0] cap_w, op_force, op_allow;
    // Model state
    int n_fail = 0, comparisons = 0, cyc = 0, exp_g = 0, gc = 0;
    int opc[3], exp_op[3], cnt[3], pre[3], lvl[3], val[3], edg[3], rin[3];
    int raw, ena, upd, ph, c, k, nv, d;
    logic [31:0] cfg[3];
    logic [1:0] resp;
    pcuirq_top dut (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(w_v), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar_addr),
        .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(1'b1), .CAPTURE_IN(cap_w), .SYNC_IN(ev[5:0]), .EVENT_IN(ev),
        .OPERATOR_FORCE_UPDATE(op_force), .OPERATOR_UPDATE_ALLOW(op_allow),
        .GLOBAL_FORCE_UPDATE(g_force), .GLOBAL_UPDATE_ALLOW(g_allow)
    );
    pcuirq_cap_src src (.clk(CORE_CLK), .rst_n(RESETN), .flip(flip), .cap(cap_w));
    // Clock
    initial begin
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    task automatic summarize();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Bus write; each channel released at its handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        aw_addr <= a;
        w_data <= v;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (aw_v && awready) aw_v <= 1'b0;
            if (w_v && wready) w_v <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        ar_addr <= a;
        ar_v <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (ar_v && arready) ar_v <= 1'b0;
        end while (rvalid !== 1'b1);
        rdv = rdata;
        resp = rresp;
    endtask : rd
    // Model capture; negative edge code keeps last edge
    task automatic take(input int ch, input int e);
        val[ch] = ph;
        if (e >= 0) edg[ch] = e;
        raw |= 1 << (INT_CAP_LO + ch);
    endtask : take
    // Prescaler and edge select model
    task automatic step(input int ch, input int nl);
        if (nl && !lvl[ch]) begin
            cnt[ch]++;
            if (cnt[ch] == cfg[ch][10:3] + 1) begin
                cnt[ch] = 0;
                pre[ch] = 1;
                if (cfg[ch][2] && cfg[ch][0]) take(ch, 0);
            end
        end else if (!nl && lvl[ch] && pre[ch]) begin
            pre[ch] = 0;
            if (cfg[ch][1] && cfg[ch][0]) take(ch, 1);
        end
        lvl[ch] = nl;
    endtask : step
    // Pulse counting and hang guard
    always @(posedge CORE_CLK) begin
        cyc++;
        for (int i = 0; i < 3; i++) opc[i] += op_force[i];
        gc += g_force;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        ph = $urandom(32'haf63fd2d);
        repeat (6) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        @(posedge CORE_CLK);
        for (int a = 'he8; a <= 'h118; a += 4) begin
            rd(12'(a));
            chk(rdv, 32'h0);
        end
        ena = $urandom & 32'h3fffffff;
        wr(INTERRUPT_ENABLE_OFS, ena);
        rd(INTERRUPT_ENABLE_OFS);
        chk(rdv, ena);
        wr(12'h200, 32'h1);
        chk(resp, RESP_SLVERR);
        wr(CAPTURE_CHANNEL0_VALUE_OFS, 32'h1);
        chk(resp, RESP_SLVERR);
        rd(12'h200);
        chk(rdv, 32'h0);
        chk(resp, RESP_SLVERR);
        cfg[0] = 32'h7;
        cfg[1] = 32'hb;
        cfg[2] = 32'h815;
        for (int i = 0; i < 3; i++) begin
            wr(CAPTURE_CHANNEL0_CONFIG_OFS + 12'(4 * i), cfg[i]);
            rd(CAPTURE_CHANNEL0_CONFIG_OFS + 12'(4 * i));
            chk(rdv, cfg[i]);
        end
        // Inverted idle line looks like a rise
        step(2, 1);
        for (int it = 0; it < 40; it++) begin
            nv = $urandom & 8'hff;
            d = nv ^ upd;
            if (d[1]) begin
                exp_g++;
                for (int i = 0; i < 3; i++) exp_op[i]++;
            end else begin
                for (int i = 0; i < 3; i++) if (d[3 + 2 * i]) exp_op[i]++;
            end
            upd = nv;
            wr(ACTIVE_UPDATE_CONTROL_OFS, nv);
            chk({g_allow, op_allow}, {nv[0], nv[6] & nv[0], nv[4] & nv[0], nv[2] & nv[0]});
            ph = $urandom;
            wr(CAPTURE_COUNTER_PHASE_OFS, ph);
            wr(CAPTURE_COUNTER_CONFIG_OFS, 32'h20);
            if (it == 20) begin
                cfg[0][0] = 1'b0;
                wr(CAPTURE_CHANNEL0_CONFIG_OFS, cfg[0]);
            end
            k = $urandom % 27;
            raw |= 1 << k;
            c = $urandom % 4;
            ev[k] <= 1'b1;
            if (c < 3) flip[c] <= 1'b1;
            @(posedge CORE_CLK);
            ev <= 27'h0;
            flip <= 3'h0;
            if (c < 3) begin
                rin[c] ^= 1;
                step(c, rin[c] ^ cfg[c][11]);
            end else begin
                c = 1 + $urandom % 2;
                wr(CAPTURE_CHANNEL0_CONFIG_OFS + 12'(4 * c), cfg[c] | 32'h1000);
                take(c, -1);
            end
            repeat (5) @(posedge CORE_CLK);
            for (int i = 0; i < 3; i++) begin
                rd(CAPTURE_CHANNEL0_VALUE_OFS + 12'(4 * i));
                chk(rdv, val[i]);
            end
            rd(CAPTURE_EDGE_STATUS_OFS);
            chk(rdv, {edg[2][0], edg[1][0], edg[0][0]});
            rd(INTERRUPT_RAW_OFS);
            chk(rdv, raw);
            rd(INTERRUPT_MASKED_OFS);
            chk(rdv, raw & ena);
            wr(INTERRUPT_RAW_OFS, 32'hffffffff);
            raw = 0;
        end
        for (int i = 0; i < 3; i++) chk(opc[i], exp_op[i]);
        chk(gc, exp_g);
        summarize();
    end
endmodule : pcuirq_tb_top
